// ==== verilog/dbs_pkg.sv ====
// depth surface state decoder: shared constants, types and helpers
// assumes a 32-bit apb register bus and a single pclk domain
package dbs_pkg;

   // ==========================================================
   // register map, byte addresses of aligned words
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_DW1 = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DW2 = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DW3 = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PITCH = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_BASE = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_EXTENT = 8'h1C;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // ==========================================================
   // command field positions and widths
   localparam int unsigned HIZ_BIT = 22;
   localparam int unsigned FMT_LO = 18;
   localparam int unsigned FMT_W = 3;
   localparam int unsigned PITCH_LO = 0;
   localparam int unsigned PITCH_W = 18;
   localparam int unsigned HEIGHT_LO = 18;
   localparam int unsigned HEIGHT_W = 14;
   localparam int unsigned WIDTH_LO = 4;
   localparam int unsigned WIDTH_W = 14;
   localparam int unsigned EXT_W = 15;
   localparam int unsigned PBYTES_W = 19;

   // ==========================================================
   // format codes and depth sizes
   localparam logic [FMT_W-1:0] FMT_CODE_FLOAT32 = 3'h1;
   localparam logic [FMT_W-1:0] FMT_CODE_UNORM24_PAD8 = 3'h3;
   localparam logic [FMT_W-1:0] FMT_CODE_UNORM16 = 3'h5;
   localparam logic [5:0] BITS_NONE = 6'h00;
   localparam logic [5:0] BITS_FLOAT32 = 6'h20;
   localparam logic [5:0] BITS_UNORM24 = 6'h18;
   localparam logic [5:0] BITS_UNORM16 = 6'h10;

   // ==========================================================
   // geometry limits
   localparam int unsigned PITCH_ALIGN_W = 7;
   localparam logic [PITCH_ALIGN_W-1:0] PITCH_ALIGN_ONES = 7'h7F;
   localparam logic [PITCH_W-1:0] PITCH_MAX_FIELD = 18'h1_FFFF;
   localparam logic [HEIGHT_W-1:0] HEIGHT_VOLUME_MAX = 14'h07FF;
   localparam logic [EXT_W-1:0] EXT_ONE = 15'h0001;
   localparam logic [PBYTES_W-1:0] PBYTES_ONE = 19'h0_0001;

   // ==========================================================
   // control and status bits
   localparam int unsigned CTRL_COMMIT_BIT = 0;
   localparam int unsigned CTRL_CLR_BIT = 1;
   localparam int unsigned ST_HIZ = 0;
   localparam int unsigned ST_KIND_LO = 1;
   localparam int unsigned ST_FMT_ERR = 4;
   localparam int unsigned ST_PITCH_ERR = 5;
   localparam int unsigned ST_VOL_OVER = 6;
   localparam int unsigned ST_VALID = 7;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      DBS_KIND_NONE,
      DBS_DEPTH_FLOAT32,
      DBS_DEPTH_UNORM24_PAD8,
      DBS_DEPTH_UNORM16
   } dbs_kind_e;

   typedef struct packed {
      logic hiz_defined;
      dbs_kind_e kind;
      logic [5:0] depth_bits;
      logic [PBYTES_W-1:0] pitch_bytes;
      logic [31:0] base_addr;
      logic [EXT_W-1:0] height;
      logic [EXT_W-1:0] width;
   } dbs_state_s;

   typedef struct packed {
      logic [PBYTES_W-1:0] pitch_bytes;
      logic [EXT_W-1:0] height;
      logic [EXT_W-1:0] width;
      logic pitch_bad;
      logic volume_over;
   } dbs_geom_s;

   // byte-lane merge for apb writes
   function automatic logic [31:0] dbs_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old_w;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return r;
   endfunction : dbs_merge

   function automatic logic dbs_mapped(input logic [ADDR_W-1:0] a);
      return (a == OFS_DW1) || (a == OFS_DW2) || (a == OFS_DW3) || (a == OFS_CTRL) ||
             (a == OFS_STATUS) || (a == OFS_PITCH) || (a == OFS_BASE) || (a == OFS_EXTENT);
   endfunction : dbs_mapped

endpackage : dbs_pkg

// ==== verilog/dbs_fmt_decode.sv ====
// depth surface state decoder: format code to depth kind
// purely combinational, fed from the staged command word
`timescale 1ns/10ps
module dbs_fmt_decode
   import dbs_pkg::*;
(
   // format code
   input wire logic [FMT_W-1:0] code,
   // decoded result
   output dbs_kind_e kind,
   output logic [5:0] depth_bits,
   output logic reserved
);

   // ==========================================================
   // decode
   always_comb begin
      kind = DBS_KIND_NONE;
      depth_bits = BITS_NONE;
      reserved = 1'b0;
      // R4 format code map
      unique case (code)
         FMT_CODE_FLOAT32: begin
            kind = DBS_DEPTH_FLOAT32;
            depth_bits = BITS_FLOAT32;
         end
         FMT_CODE_UNORM24_PAD8: begin
            kind = DBS_DEPTH_UNORM24_PAD8;
            depth_bits = BITS_UNORM24;
         end
         FMT_CODE_UNORM16: begin
            kind = DBS_DEPTH_UNORM16;
            depth_bits = BITS_UNORM16;
         end
         // R11 reserved codes flagged
         default: begin
            reserved = 1'b1;
         end
      endcase
   end

endmodule : dbs_fmt_decode

// ==== verilog/dbs_geom_decode.sv ====
// depth surface state decoder: pitch and extent fields
// purely combinational, fed from the staged command words
`timescale 1ns/10ps
module dbs_geom_decode
   import dbs_pkg::*;
(
   // raw fields
   input wire logic [PITCH_W-1:0] pitch_field,
   input wire logic [HEIGHT_W-1:0] height_field,
   input wire logic [WIDTH_W-1:0] width_field,
   // decoded result
   output dbs_geom_s geom
);

   // ==========================================================
   // decode
   always_comb begin
      // R5 pitch minus one
      geom.pitch_bytes = {1'b0, pitch_field} + PBYTES_ONE;
      // pitch must be a 128 byte multiple within range
      geom.pitch_bad = (pitch_field[PITCH_ALIGN_W-1:0] != PITCH_ALIGN_ONES) ||
                       (pitch_field > PITCH_MAX_FIELD);
      // R8 height minus one
      geom.height = {1'b0, height_field} + EXT_ONE;
      // surface kind unknown here, so only report the volume limit
      geom.volume_over = height_field > HEIGHT_VOLUME_MAX;
      // R10 width minus one
      geom.width = {1'b0, width_field} + EXT_ONE;
   end

endmodule : dbs_geom_decode

// ==== verilog/dbs_decode.sv ====
// depth surface state decoder: apb register file and decoded state
// assumes an apb4 master on pclk and a pipeline that samples depth_state
//
// Summary of operation
// R1 - hiz enable marks auxiliary surface defined
// R2 - issuer sets hiz only in normal tiling
// R3 - issuer clears hiz without early depth
// R4 - format codes one, three, five decode
// R5 - pitch field is bytes minus one
// R6 - base address taken as full word
// R7 - issuer aligns linear base, uncached memory
// R8 - height field is height minus one
// R9 - issuer matches depth and target height
// R10 - width field is width minus one
// R11 - reserved bits ignored, reserved format rejected
`timescale 1ns/10ps
module dbs_decode
   import dbs_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // decoded state to the pipeline
   output dbs_state_s depth_state,
   output logic state_load,
   output logic cfg_error
);

   // ==========================================================
   // bus strobes
   logic wr_en;
   logic rd_setup;
   logic commit_req;
   logic clear_req;
   logic commit_ok;

   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !dbs_mapped(paddr);
   assign commit_req = wr_en && (paddr == OFS_CTRL) && pstrb[0] && pwdata[CTRL_COMMIT_BIT];
   assign clear_req = wr_en && (paddr == OFS_CTRL) && pstrb[0] && pwdata[CTRL_CLR_BIT];

   // ==========================================================
   // staged command words
   logic [31:0] dw1_ff;
   logic [31:0] dw2_ff;
   logic [31:0] dw3_ff;
   logic [31:0] nxt_dw1;
   logic [31:0] nxt_dw2;
   logic [31:0] nxt_dw3;

   always_comb begin
      nxt_dw1 = dw1_ff;
      nxt_dw2 = dw2_ff;
      nxt_dw3 = dw3_ff;
      if (wr_en && (paddr == OFS_DW1)) begin
         nxt_dw1 = dbs_merge(dw1_ff, pwdata, pstrb);
      end
      if (wr_en && (paddr == OFS_DW2)) begin
         nxt_dw2 = dbs_merge(dw2_ff, pwdata, pstrb);
      end
      if (wr_en && (paddr == OFS_DW3)) begin
         nxt_dw3 = dbs_merge(dw3_ff, pwdata, pstrb);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dw1_ff <= RST_WORD;
         dw2_ff <= RST_WORD;
         dw3_ff <= RST_WORD;
      end else begin
         dw1_ff <= nxt_dw1;
         dw2_ff <= nxt_dw2;
         dw3_ff <= nxt_dw3;
      end
   end

   // ==========================================================
   // field decoders
   dbs_kind_e dec_kind;
   logic [5:0] dec_bits;
   logic dec_rsvd;
   dbs_geom_s dec_geom;

   dbs_fmt_decode u_fmt (
      .code(dw1_ff[FMT_LO +: FMT_W]),
      .kind(dec_kind),
      .depth_bits(dec_bits),
      .reserved(dec_rsvd)
   );

   dbs_geom_decode u_geom (
      .pitch_field(dw1_ff[PITCH_LO +: PITCH_W]),
      .height_field(dw3_ff[HEIGHT_LO +: HEIGHT_W]),
      .width_field(dw3_ff[WIDTH_LO +: WIDTH_W]),
      .geom(dec_geom)
   );

   // R11 reserved format blocks the load
   assign commit_ok = commit_req && !dec_rsvd;

   // ==========================================================
   // decoded state
   dbs_state_s state_ff;
   dbs_state_s nxt_state;
   logic load_ff;
   logic nxt_load;

   always_comb begin
      nxt_state = state_ff;
      nxt_load = commit_ok;
      if (commit_ok) begin
         // R1 hiz surface defined
         nxt_state.hiz_defined = dw1_ff[HIZ_BIT];
         nxt_state.kind = dec_kind;
         nxt_state.depth_bits = dec_bits;
         nxt_state.pitch_bytes = dec_geom.pitch_bytes;
         // R6 full base address
         nxt_state.base_addr = dw2_ff;
         nxt_state.height = dec_geom.height;
         nxt_state.width = dec_geom.width;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= '0;
         load_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         load_ff <= nxt_load;
      end
   end

   assign depth_state = state_ff;
   assign state_load = load_ff;

   // ==========================================================
   // status flags
   logic fmt_err_ff;
   logic pitch_err_ff;
   logic vol_over_ff;
   logic valid_ff;
   logic nxt_fmt_err;
   logic nxt_pitch_err;
   logic nxt_vol_over;
   logic nxt_valid;

   always_comb begin
      nxt_fmt_err = fmt_err_ff;
      nxt_pitch_err = pitch_err_ff;
      nxt_vol_over = vol_over_ff;
      nxt_valid = valid_ff;
      if (clear_req) begin
         nxt_fmt_err = 1'b0;
         nxt_pitch_err = 1'b0;
      end
      // R11 reserved format sets error, set beats clear
      if (commit_req && dec_rsvd) begin
         nxt_fmt_err = 1'b1;
      end
      // R5 pitch alignment and range check
      if (commit_ok && dec_geom.pitch_bad) begin
         nxt_pitch_err = 1'b1;
      end
      // R8 volume height limit reported
      if (commit_ok) begin
         nxt_vol_over = dec_geom.volume_over;
         nxt_valid = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_err_ff <= 1'b0;
         pitch_err_ff <= 1'b0;
         vol_over_ff <= 1'b0;
         valid_ff <= 1'b0;
      end else begin
         fmt_err_ff <= nxt_fmt_err;
         pitch_err_ff <= nxt_pitch_err;
         vol_over_ff <= nxt_vol_over;
         valid_ff <= nxt_valid;
      end
   end

   assign cfg_error = fmt_err_ff || pitch_err_ff;

   // ==========================================================
   // read data, captured in the setup cycle so access is zero wait
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic [31:0] status_word;

   always_comb begin
      status_word = RST_WORD;
      status_word[ST_HIZ] = state_ff.hiz_defined;
      status_word[ST_KIND_LO +: 2] = state_ff.kind;
      status_word[ST_FMT_ERR] = fmt_err_ff;
      status_word[ST_PITCH_ERR] = pitch_err_ff;
      status_word[ST_VOL_OVER] = vol_over_ff;
      status_word[ST_VALID] = valid_ff;
   end

   always_comb begin
      nxt_prdata = prdata_ff;
      if (rd_setup) begin
         unique case (paddr)
            OFS_DW1: nxt_prdata = dw1_ff;
            OFS_DW2: nxt_prdata = dw2_ff;
            OFS_DW3: nxt_prdata = dw3_ff;
            OFS_STATUS: nxt_prdata = status_word;
            OFS_PITCH: nxt_prdata = {13'h0000, state_ff.pitch_bytes};
            OFS_BASE: nxt_prdata = state_ff.base_addr;
            OFS_EXTENT: nxt_prdata = {1'b0, state_ff.height, 1'b0, state_ff.width};
            // ctrl is write only; unmapped reads zero
            default: nxt_prdata = RST_WORD;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= RST_WORD;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata = prdata_ff;

   // ==========================================================
   // checks
   a_hiz_on_load: assert property (@(posedge pclk) disable iff (!presetn) // R1
      commit_ok |=> (depth_state.hiz_defined == $past(dw1_ff[HIZ_BIT])) && state_load)
      else $error("hiz flag not loaded");

   a_fmt_float32: assert property (@(posedge pclk) disable iff (!presetn) // R4
      commit_req && (dw1_ff[FMT_LO +: FMT_W] == FMT_CODE_FLOAT32)
      |=> (depth_state.kind == DBS_DEPTH_FLOAT32) && (depth_state.depth_bits == BITS_FLOAT32))
      else $error("float32 format decoded wrong");

   a_fmt_unorm: assert property (@(posedge pclk) disable iff (!presetn) // R4
      commit_req && (dw1_ff[FMT_LO +: FMT_W] == FMT_CODE_UNORM16)
      |=> (depth_state.kind == DBS_DEPTH_UNORM16) && (depth_state.depth_bits == BITS_UNORM16))
      else $error("unorm16 format decoded wrong");

   a_pitch_plus_one: assert property (@(posedge pclk) disable iff (!presetn) // R5
      commit_ok |=> depth_state.pitch_bytes ==
      ({1'b0, $past(dw1_ff[PITCH_LO +: PITCH_W])} + PBYTES_ONE))
      else $error("pitch bytes wrong");

   a_pitch_flag: assert property (@(posedge pclk) disable iff (!presetn) // R5
      commit_ok && (dw1_ff[PITCH_ALIGN_W-1:0] != PITCH_ALIGN_ONES) |=> pitch_err_ff [*2])
      else $error("misaligned pitch not flagged");

   a_base_word: assert property (@(posedge pclk) disable iff (!presetn) // R6
      commit_ok |=> depth_state.base_addr == $past(dw2_ff))
      else $error("base address not loaded");

   a_height_ext: assert property (@(posedge pclk) disable iff (!presetn) // R8
      commit_ok |=> (depth_state.height ==
      ({1'b0, $past(dw3_ff[HEIGHT_LO +: HEIGHT_W])} + EXT_ONE)) &&
      (vol_over_ff == ($past(dw3_ff[HEIGHT_LO +: HEIGHT_W]) > HEIGHT_VOLUME_MAX)))
      else $error("height decode wrong");

   a_width_ext: assert property (@(posedge pclk) disable iff (!presetn) // R10
      commit_ok |=> depth_state.width ==
      ({1'b0, $past(dw3_ff[WIDTH_LO +: WIDTH_W])} + EXT_ONE))
      else $error("width decode wrong");

   a_rsvd_keeps: assert property (@(posedge pclk) disable iff (!presetn) // R11
      commit_req && dec_rsvd |=> $stable(depth_state) && fmt_err_ff && !state_load)
      else $error("reserved format changed state");

   a_fmt_unorm24: assert property (@(posedge pclk) disable iff (!presetn) // R4
      commit_req && (dw1_ff[FMT_LO +: FMT_W] == FMT_CODE_UNORM24_PAD8)
      |=> (depth_state.kind == DBS_DEPTH_UNORM24_PAD8) &&
      (depth_state.depth_bits == BITS_UNORM24))
      else $error("unorm24 format decoded wrong");

   a_pitch_range: assert property (@(posedge pclk) disable iff (!presetn) // R5
      commit_ok && (dw1_ff[PITCH_LO +: PITCH_W] > PITCH_MAX_FIELD) |=> pitch_err_ff)
      else $error("oversize pitch not flagged");

   a_load_pulse: assert property (@(posedge pclk) disable iff (!presetn) // R1
      state_load |-> $past(commit_ok))
      else $error("load pulse without commit");

   a_clear_flags: assert property (@(posedge pclk) disable iff (!presetn) // R11
      clear_req && !commit_req |=> !cfg_error)
      else $error("error flags not cleared");

endmodule : dbs_decode

// ==== sim/dbs_streamer.sv ====
// ==========================================================
// command streamer model: apb master issuing depth surface commands
// assumes pclk from the bench; one idle cycle follows each transfer
`timescale 1ns/10ps
module dbs_streamer
   import dbs_pkg::*;
(
   // clock
   input wire logic pclk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'h0;
   end

   // ==========================================================
   // one apb transfer on all byte lanes
   task automatic xfer(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      xfer_lanes(we, a, wd, 4'hF, rd, err);
   endtask : xfer

   // ==========================================================
   // one apb transfer on chosen lanes, held until pready is seen at an edge
   task automatic xfer_lanes(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                             input logic [3:0] strb, output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= we;
      paddr <= a;
      pwdata <= wd;
      pstrb <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle cycle so the next setup never lands in this time step
      @(posedge pclk);
   endtask : xfer_lanes

   // ==========================================================
   // caller gates hiz; rsv nonzero only on purpose
   task automatic send_cmd(input logic hiz, input logic [2:0] fmt, input logic [17:0] pf,
                           input logic [31:0] base, input logic [13:0] hf,
                           input logic [13:0] wf, input logic [4:0] rsv);
      logic [31:0] d;
      logic e;
      xfer(1'b1, OFS_DW1, {5'h00, rsv[4:1], hiz, rsv[0], fmt, pf}, d, e);
      // linear base kept on a 64-byte boundary
      xfer(1'b1, OFS_DW2, base & 32'hFFFF_FFC0, d, e);
      // hf is the render target height minus one
      xfer(1'b1, OFS_DW3, {hf, wf, 4'h0}, d, e);
      xfer(1'b1, OFS_CTRL, 32'h0000_0001, d, e);
   endtask : send_cmd
endmodule : dbs_streamer

// ==== sim/test_depth_buffer_state_decode.sv ====
// ==========================================================
// bench for the depth surface state decoder
// assumes dbs_decode and the streamer model; no random stimulus
`timescale 1ns/10ps
module test_depth_buffer_state_decode
   import dbs_pkg::*;
;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   dbs_state_s depth_state;
   logic state_load;
   logic cfg_error;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   int loads = 0;

   dbs_decode u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .depth_state(depth_state),
      .state_load(state_load), .cfg_error(cfg_error));

   dbs_streamer u_str (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ==========================================================
   // load pulses counted mid-cycle, away from the driving edge
   always @(negedge pclk) begin
      cycles++;
      if (state_load === 1'b1) begin
         loads++;
      end
      if (cycles == 3000) begin
         mismatches++;
         test_done();
      end
   end

   task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic test_done;
      if (mismatches == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] d;
      logic e;
      logic [17:0] pf;
      logic [13:0] hf;
      logic [31:0] b;
      int n;
      dbs_state_s prev;
      dbs_state_s exp;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("reset state", 96'h0, depth_state);
      u_str.xfer(1'b0, OFS_STATUS, 32'h0, d, e);
      check("reset status", 96'h0, d);
      // every format code, top legal pitch on odd codes and bottom legal pitch on even ones, height near 2047
      for (int c = 0; c < 8; c++) begin
         prev = depth_state;
         n = loads;
         pf = c[0] ? 18'h1_FFFF : 18'h0_007F;
         hf = 14'h07FC + c[13:0];
         b = {c[2:0], 29'h0ABC_DE40};
         u_str.send_cmd(c[1], c[2:0], pf, b, hf, c[13:0], 5'h00);
         if (c == 1 || c == 3 || c == 5) begin
            // kind is (code+1)/2, depth bits 36-4*code
            exp = '{c[1], dbs_kind_e'((c + 1) / 2), 6'(36 - 4 * c), {1'b0, pf} + 19'h0_0001,
                    b, {1'b0, hf} + 15'h0001, {1'b0, c[13:0]} + 15'h0001};
            check("load count", n + 1, loads);
            check("state", exp, depth_state);
            check("cfg_error", 96'h0, cfg_error);
            u_str.xfer(1'b0, OFS_STATUS, 32'h0, d, e);
            check("status", {hf > 14'h07FF, 3'b000, exp.kind, c[1]} | 96'h80, d);
            u_str.xfer(1'b0, OFS_PITCH, 32'h0, d, e);
            check("pitch", exp.pitch_bytes, d);
            u_str.xfer(1'b0, OFS_BASE, 32'h0, d, e);
            check("base", b, d);
            u_str.xfer(1'b0, OFS_EXTENT, 32'h0, d, e);
            check("extent", {1'b0, exp.height, 1'b0, exp.width}, d);
         end else begin
            check("load count", n, loads);
            check("held state", prev, depth_state);
            check("cfg_error", 96'h1, cfg_error);
            u_str.xfer(1'b0, OFS_STATUS, 32'h0, d, e);
            check("fmt_err", 96'h1, d[4]);
            u_str.xfer(1'b1, OFS_CTRL, 32'h0000_0002, d, e);
            check("cleared", 96'h0, cfg_error);
         end
      end
      // reserved bits set on purpose, decode must not change; max extents
      u_str.send_cmd(1'b1, 3'h3, 18'h0_00FF, 32'h0000_0040, 14'h3FFF, 14'h3FFF, 5'h1F);
      exp = '{1'b1, DBS_DEPTH_UNORM24_PAD8, 6'h18, 19'h0_0100, 32'h0000_0040,
              15'h4000, 15'h4000};
      check("rsv ignored", exp, depth_state);
      // pitch not a multiple of 128: flagged, still loaded
      n = loads;
      u_str.send_cmd(1'b0, 3'h5, 18'h0_0080, 32'h0, 14'h0, 14'h0, 5'h00);
      check("pitch load", n + 1, loads);
      check("pitch err", 96'h1, cfg_error);
      u_str.xfer(1'b0, OFS_STATUS, 32'h0, d, e);
      check("pitch flag", 96'h1, d[5]);
      // commit and clear together: set wins
      u_str.xfer(1'b1, OFS_CTRL, 32'h0000_0003, d, e);
      check("set wins", 96'h1, cfg_error);
      u_str.xfer(1'b1, OFS_CTRL, 32'h0000_0002, d, e);
      check("clear", 96'h0, cfg_error);
      // aligned pitch above 128 kilobytes is out of range
      n = loads;
      u_str.send_cmd(1'b0, 3'h1, 18'h2_007F, 32'h0, 14'h0, 14'h0, 5'h00);
      check("range load", n + 1, loads);
      check("range err", 96'h1, cfg_error);
      u_str.xfer(1'b1, OFS_CTRL, 32'h0000_0002, d, e);
      check("range clear", 96'h0, cfg_error);
      // read-only and unmapped places
      u_str.xfer(1'b1, OFS_BASE, 32'hFFFF_FFFF, d, e);
      u_str.xfer(1'b0, OFS_BASE, 32'h0, d, e);
      check("base ro", 96'h0, d);
      u_str.xfer(1'b0, OFS_CTRL, 32'h0, d, e);
      check("ctrl read", 96'h0, {e, d});
      u_str.xfer(1'b0, 8'h20, 32'h0, d, e);
      check("unmapped rd", 96'h1_0000_0000, {e, d});
      u_str.xfer(1'b1, 8'h24, 32'h1, d, e);
      check("unmapped wr", 96'h1, e);
      // byte lanes: only enabled lanes land, commit needs lane 0
      u_str.xfer(1'b1, OFS_DW2, 32'h1234_5678, d, e);
      u_str.xfer_lanes(1'b1, OFS_DW2, 32'hAABB_CCDD, 4'h5, d, e);
      u_str.xfer(1'b0, OFS_DW2, 32'h0, d, e);
      check("dw2 lanes", 96'h12BB_56DD, d);
      n = loads;
      u_str.xfer_lanes(1'b1, OFS_CTRL, 32'h0000_0001, 4'hE, d, e);
      check("lane0 commit", n, loads);
      // reset again mid-run: everything back to idle
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("reset again", 96'h0, {cfg_error, depth_state});
      u_str.xfer(1'b0, OFS_STATUS, 32'h0, d, e);
      check("status again", 96'h0, d);
      test_done();
   end
endmodule : test_depth_buffer_state_decode
